// >>> inc/hes_pkg.sv
package hes_pkg;

    // ------------------------------------------------------------
    // object dictionary indices
    // ------------------------------------------------------------
    localparam logic [15:0] HES_IDX_CMD = 16'h6040;
    localparam logic [15:0] HES_IDX_STATE = 16'h6041;
    localparam logic [15:0] HES_IDX_HALT_OPT = 16'h605D;
    localparam logic [15:0] HES_IDX_METHOD = 16'h6098;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [15:0] HES_CMD_RST = 16'h0000;
    localparam logic [15:0] HES_STATE_RST = 16'h0000;
    localparam logic [7:0] HES_METHOD_RST = 8'h00;
    localparam logic [15:0] HES_HALT_OPT_RST = 16'h0001;

    // ------------------------------------------------------------
    // command word fields
    // ------------------------------------------------------------
    localparam int HES_CMD_SWITCH_ON = 0;
    localparam int HES_CMD_VOLTAGE = 1;
    localparam int HES_CMD_QSTOP = 2;
    localparam int HES_CMD_ENA_OP = 3;
    localparam int HES_CMD_TRIGGER = 4;
    localparam int HES_CMD_HALT = 8;
    localparam logic [3:0] HES_CMD_ENA_ALL = 4'hF;

    // ------------------------------------------------------------
    // state word fields
    // ------------------------------------------------------------
    localparam int HES_ST_TARGET = 10;
    localparam int HES_ST_SPEED0 = 12;
    localparam int HES_ST_HOMED = 15;

    // ------------------------------------------------------------
    // homing method codes and halt option
    // ------------------------------------------------------------
    localparam logic [7:0] HES_M_SW_POS_LOW = 8'h1C;
    localparam logic [7:0] HES_M_SW_MID = 8'h1D;
    localparam logic [7:0] HES_M_SW_NEG = 8'h1E;
    localparam logic [7:0] HES_M_IDX_NEG = 8'h21;
    localparam logic [7:0] HES_M_IDX_POS = 8'h22;
    localparam logic [7:0] HES_M_HERE = 8'h23;
    localparam logic [15:0] HES_HALT_QUICK = 16'h0002;

    // ------------------------------------------------------------
    // sequencer phases and motion command
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        HES_IDLE = 3'b000,
        HES_HI_NEG = 3'b001,
        HES_HI_POS = 3'b010,
        HES_WAIT_FALL = 3'b011,
        HES_WAIT_RISE = 3'b100,
        HES_WAIT_INDEX = 3'b101,
        HES_DONE = 3'b110
    } hes_phase_t;

    typedef struct packed {
        logic run;
        logic neg;
        logic fast;
        logic quick;
    } hes_motion_t;

endpackage

// >>> sim/hes_host.sv
`timescale 1ns/1ns
// --------------------------------------------------------------
// host controller model on the object port
// --------------------------------------------------------------
module hes_host (
    // clock
    input wire logic clk_i,
    // object access port
    output logic obj_wr_o,
    output logic obj_rd_o,
    output logic [15:0] obj_index_o,
    output logic [15:0] obj_wdata_o
);
    import hes_pkg::*;

    // read results still owed by the device, oldest first
    logic [15:0] exp_q[$];

    // idle bus at time zero
    initial begin
        obj_wr_o = 1'b0;
        obj_rd_o = 1'b0;
        obj_index_o = 16'h0000;
        obj_wdata_o = 16'h0000;
    end

    // one write pulse; after the taking edge the lines show the
    // inverse so a stale value can never pass for a held one
    task automatic wr(input logic [15:0] idx, input logic [15:0] d);
        @(negedge clk_i);
        obj_wr_o = 1'b1;
        obj_index_o = idx;
        obj_wdata_o = d;
        @(negedge clk_i);
        obj_wr_o = 1'b0;
        obj_index_o = ~idx;
        obj_wdata_o = ~d;
    endtask

    // one read pulse, noting the value the device should return
    task automatic rd(input logic [15:0] idx, input logic [15:0] e);
        @(negedge clk_i);
        obj_rd_o = 1'b1;
        obj_index_o = idx;
        exp_q.push_back(e);
        @(negedge clk_i);
        obj_rd_o = 1'b0;
        obj_index_o = ~idx;
    endtask

    // homing start: method first, then enable bits, then the trigger
    task automatic start(input logic [7:0] method);
        wr(HES_IDX_METHOD, {8'h00, method});
        wr(HES_IDX_CMD, 16'h000F);
        wr(HES_IDX_CMD, 16'h001F);
    endtask
endmodule // hes_host

// >>> sim/homing_edge_sequencer_tb.sv
`timescale 1ns/1ns
// --------------------------------------------------------------
// self-checking bench for the homing sequencer
// --------------------------------------------------------------
module homing_edge_sequencer_tb;
    import hes_pkg::*;

    logic clk_i = 1'b0;
    logic resetn_i;
    logic obj_wr, obj_rd, rvalid, home_set;
    logic [15:0] obj_index, obj_wdata, rdata, state;
    logic sw, lim, idx, sz, tr, pv;
    hes_motion_t motion;
    int failures = 0;
    int checked = 0;
    logic [15:0] pulses = 16'h0000;
    logic [15:0] exp_pulses = 16'h0000;

    // 50 MHz clock
    always #10 clk_i = ~clk_i;

    hes_host host_u (
        .clk_i(clk_i), .obj_wr_o(obj_wr), .obj_rd_o(obj_rd),
        .obj_index_o(obj_index), .obj_wdata_o(obj_wdata)
    );

    hes_sequencer dut_u (
        .clk_i(clk_i), .resetn_i(resetn_i),
        .obj_wr_i(obj_wr), .obj_rd_i(obj_rd),
        .obj_index_i(obj_index), .obj_wdata_i(obj_wdata),
        .obj_rdata_o(rdata), .obj_rvalid_o(rvalid),
        .home_switch_input_i(sw), .neg_limit_i(lim),
        .index_pulse_i(idx), .speed_zero_i(sz),
        .target_reached_i(tr), .profile_velocity_operation_i(pv),
        .motion_o(motion), .home_set_o(home_set),
        .drive_state_word_o(state)
    );

    task automatic stop_test();
        // a read still owed at the end is a lost answer
        if (host_u.exp_q.size() != 0) begin
            failures++;
        end
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic cmp16(input logic [15:0] got, input logic [15:0] e);
        checked++;
        if (got !== e) begin
            failures++;
            $display("unexpected at %0t: got %h expected %h", $time, got, e);
        end
    endtask

    task automatic cmp4(input logic [3:0] got, input logic [3:0] e);
        checked++;
        if (got !== e) begin
            failures++;
            $display("unexpected at %0t: got %h expected %h", $time, got, e);
        end
    endtask

    // state word expected from the present sensor levels
    function automatic logic [15:0] exp_state(input logic homed,
                                              input logic halt);
        logic [15:0] s;
        s = 16'h0000;
        s[HES_ST_HOMED] = homed;
        s[HES_ST_SPEED0] = pv & sz;
        s[HES_ST_TARGET] = halt ? sz : tr;
        return s;
    endfunction

    // random feedback levels, settle, then read the state word
    task automatic rd_state(input logic homed, input logic halt);
        @(negedge clk_i);
        {sz, tr, pv} = 3'($urandom());
        repeat (3) @(negedge clk_i);
        host_u.rd(HES_IDX_STATE, exp_state(homed, halt));
        cmp16(state, exp_state(homed, halt));
    endtask

    // each step: {switch, limit, index, expected run/neg/fast/quick};
    // step 0 gives the levels at start, the last step the stop;
    // a stopped axis keeps showing the direction of its last leg
    task automatic run_seq(input logic [7:0] method,
                           input logic [6:0] st[$]);
        @(negedge clk_i);
        {sw, lim, idx} = st[0][6:4];
        repeat (4) @(negedge clk_i);
        host_u.start(method);
        for (int i = 0; i < st.size(); i++) begin
            if (i > 0) begin
                {sw, lim, idx} = st[i][6:4];
            end
            repeat (4) @(negedge clk_i);
            cmp4(4'(motion), st[i][3:0]);
            if (i == 0 && st.size() > 1) begin
                rd_state(1'b0, 1'b0);
            end
        end
        exp_pulses = exp_pulses + 16'h0001;
        rd_state(1'b1, 1'b0);
        cmp16(pulses, exp_pulses);
    endtask

    // result watcher: read answers against the oldest note
    always @(posedge clk_i) begin
        if (home_set === 1'b1) begin
            pulses <= pulses + 16'h0001;
        end
        if (rvalid === 1'b1) begin
            if (host_u.exp_q.size() == 0) begin
                failures++;
                $display("unexpected read at %0t: got %h", $time, rdata);
            end else begin
                cmp16(rdata, host_u.exp_q.pop_front());
            end
        end
    end

    // hang guard well beyond the longest sequence
    initial begin
        #1000000;
        failures++;
        stop_test();
    end

    initial begin
        resetn_i = 1'b0;
        {sw, lim, idx, sz, tr, pv} = 6'h00;
        void'($urandom(32'h8060));
        repeat (10) @(posedge clk_i);
        @(negedge clk_i);
        resetn_i = 1'b1;
        // reset values, read-only state word, unmapped index
        host_u.wr(HES_IDX_STATE, 16'hFFFF);
        host_u.wr(16'h1234, 16'hFFFF);
        host_u.rd(HES_IDX_CMD, HES_CMD_RST);
        host_u.rd(HES_IDX_HALT_OPT, HES_HALT_OPT_RST);
        host_u.rd(HES_IDX_METHOD, {8'h00, HES_METHOD_RST});
        host_u.rd(HES_IDX_STATE, HES_STATE_RST);
        host_u.rd(16'h1234, 16'h0000);
        // every method and start condition
        run_seq(HES_M_HERE, {7'h00});
        host_u.rd(HES_IDX_CMD, 16'h001F);
        run_seq(HES_M_SW_POS_LOW, {7'h0E, 7'h48, 7'h0C, 7'h44});
        run_seq(HES_M_SW_POS_LOW,
                {7'h0E, 7'h2A, 7'h0A, 7'h48, 7'h0C, 7'h44});
        run_seq(HES_M_SW_POS_LOW, {7'h48, 7'h0C, 7'h44});
        run_seq(HES_M_SW_MID, {7'h0E, 7'h4C, 7'h08, 7'h40});
        run_seq(HES_M_SW_MID,
                {7'h0E, 7'h2A, 7'h0A, 7'h4C, 7'h08, 7'h40});
        run_seq(HES_M_SW_MID, {7'h4C, 7'h08, 7'h40});
        run_seq(HES_M_SW_NEG, {7'h0E, 7'h4C, 7'h04});
        run_seq(HES_M_SW_NEG,
                {7'h0E, 7'h2A, 7'h0A, 7'h4C, 7'h04});
        run_seq(HES_M_SW_NEG, {7'h4C, 7'h04});
        run_seq(HES_M_IDX_NEG, {7'h0C, 7'h14});
        run_seq(HES_M_IDX_POS, {7'h08, 7'h10});
        // unknown method leaves the axis still
        {sw, lim, idx} = 3'h0;
        host_u.start(8'h05);
        repeat (4) @(negedge clk_i);
        cmp4(4'(motion), 4'h0);
        // clearing an enable bit mid-run aborts the motion
        host_u.start(HES_M_IDX_POS);
        repeat (4) @(negedge clk_i);
        cmp4(4'(motion), 4'h8);
        host_u.wr(HES_IDX_CMD, 16'h0007);
        repeat (4) @(negedge clk_i);
        cmp4(4'(motion), 4'h0);
        // halt with quick-stop option, then zero-speed reporting
        host_u.wr(HES_IDX_HALT_OPT, HES_HALT_QUICK);
        host_u.rd(HES_IDX_HALT_OPT, HES_HALT_QUICK);
        host_u.start(HES_M_IDX_NEG);
        repeat (4) @(negedge clk_i);
        cmp4(4'(motion), 4'hC);
        host_u.wr(HES_IDX_CMD, 16'h011F);
        repeat (4) @(negedge clk_i);
        cmp4(4'(motion) & 4'h9, 4'h1);
        rd_state(1'b0, 1'b1);
        rd_state(1'b0, 1'b1);
        repeat (4) @(negedge clk_i);
        stop_test();
    end
endmodule // homing_edge_sequencer_tb

// >>> src/hes_edge_det.sv
`timescale 1ns/1ns
// registered level with one-cycle rising and falling pulses
module hes_edge_det (
    // clock and reset
    input wire logic clk_i,
    input wire logic resetn_i,
    // sampled level
    input wire logic level_i,
    // results
    output logic level_o,
    output logic rise_o,
    output logic fall_o
);

    // ------------------------------------------------------------
    // edge detection
    // ------------------------------------------------------------
    logic prev;

    // prev holds the same sample as level_o so the pulses line up with the held level
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            prev <= 1'b0;
            level_o <= 1'b0;
            rise_o <= 1'b0;
            fall_o <= 1'b0;
        end else begin
            prev <= level_i;
            level_o <= level_i;
            rise_o <= level_i && !prev;
            fall_o <= !level_i && prev;
        end
    end

endmodule // hes_edge_det

// >>> src/hes_sequencer.sv
`timescale 1ns/1ns
// Operation
// [RULE1] m28 inactive: fast negative, rise gives slow positive
// [RULE2] m28 limit: fast positive, rise, fall, stop rise
// [RULE3] m28 active: slow positive, fall gives slow negative
// [RULE4] mid inactive: fast neg, slow neg, reverse, stop
// [RULE5] mid limit: fast positive, rise reverses slow negative
// [RULE6] mid active: slow negative, fall reverses, stop rise
// [RULE7] m30 inactive: fast negative then slow negative
// [RULE8] m30 limit: fast positive, rise reverses, fall stops
// [RULE9] m30 active: slow negative, stop on fall
// [RULE10] m33: slow negative, stop at index
// [RULE11] m34: slow positive, stop at index
// [RULE12] m35: home here, command 0F to 1F
// [RULE13] method object picks behaviour; index no slowdown
// [RULE14] run only with command bits 0-3 set
// [RULE15] halt bit stops axis per halt option
// [RULE16] target bit: reached, or zero speed on halt
// [RULE17] profile velocity: bit 12 means zero speed
// [RULE18] homed bit set at finish, clear before
module hes_sequencer (
    // clock and reset
    input wire logic clk_i,
    input wire logic resetn_i,
    // object access port
    input wire logic obj_wr_i,
    input wire logic obj_rd_i,
    input wire logic [15:0] obj_index_i,
    input wire logic [15:0] obj_wdata_i,
    output logic [15:0] obj_rdata_o,
    output logic obj_rvalid_o,
    // sensors and drive feedback
    input wire logic home_switch_input_i,
    input wire logic neg_limit_i,
    input wire logic index_pulse_i,
    input wire logic speed_zero_i,
    input wire logic target_reached_i,
    input wire logic profile_velocity_operation_i,
    // motion command and homing result
    output hes_pkg::hes_motion_t motion_o,
    output logic home_set_o,
    output logic [15:0] drive_state_word_o
);
    import hes_pkg::*;

    // ------------------------------------------------------------
    // object registers
    // ------------------------------------------------------------
    logic [15:0] drive_command_word;
    logic [15:0] drive_state_word;
    logic [15:0] halt_option;
    logic [7:0] homing_method;
    logic start_pulse;

    wire cmd_wr = obj_wr_i && (obj_index_i == HES_IDX_CMD);
    wire enabled = drive_command_word[3:0] == HES_CMD_ENA_ALL;
    wire halted = drive_command_word[HES_CMD_HALT];
    // trigger only on a 0 to 1 step of bit 4 while enabled
    wire trigger = cmd_wr && obj_wdata_i[HES_CMD_TRIGGER]
        && (obj_wdata_i[3:0] == HES_CMD_ENA_ALL)
        && !drive_command_word[HES_CMD_TRIGGER];

    // writes to the command, method and halt option objects
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            drive_command_word <= HES_CMD_RST;
            homing_method <= HES_METHOD_RST;
            halt_option <= HES_HALT_OPT_RST;
        end else if (obj_wr_i) begin
            if (obj_index_i == HES_IDX_CMD) begin
                drive_command_word <= obj_wdata_i;
            end else if (obj_index_i == HES_IDX_METHOD) begin
                homing_method <= obj_wdata_i[7:0];
            end else if (obj_index_i == HES_IDX_HALT_OPT) begin
                halt_option <= obj_wdata_i;
            end
        end
    end

    // a start is held one cycle so the new enables are in place
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            start_pulse <= 1'b0;
        end else begin
            start_pulse <= trigger; // [RULE12]
        end
    end

    // reads answer one cycle later; unknown indices read zero
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            obj_rdata_o <= 16'h0000;
            obj_rvalid_o <= 1'b0;
        end else begin
            obj_rvalid_o <= obj_rd_i;
            if (!obj_rd_i) begin
                obj_rdata_o <= 16'h0000;
            end else if (obj_index_i == HES_IDX_CMD) begin
                obj_rdata_o <= drive_command_word;
            end else if (obj_index_i == HES_IDX_STATE) begin
                obj_rdata_o <= drive_state_word;
            end else if (obj_index_i == HES_IDX_METHOD) begin
                obj_rdata_o <= {8'h00, homing_method};
            end else if (obj_index_i == HES_IDX_HALT_OPT) begin
                obj_rdata_o <= halt_option;
            end else begin
                obj_rdata_o <= 16'h0000;
            end
        end
    end

    // ------------------------------------------------------------
    // switch and index edges
    // ------------------------------------------------------------
    logic sw_level;
    logic sw_rise;
    logic sw_fall;
    logic idx_rise;

    hes_edge_det u_switch_edge (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .level_i(home_switch_input_i),
        .level_o(sw_level),
        .rise_o(sw_rise),
        .fall_o(sw_fall)
    );

    hes_edge_det u_index_edge (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .level_i(index_pulse_i),
        .level_o(),
        .rise_o(idx_rise),
        .fall_o()
    );

    // ------------------------------------------------------------
    // homing sequencer
    // ------------------------------------------------------------
    hes_phase_t phase;
    logic leg_neg;
    logic leg_fast;
    logic homed;

    wire m28 = homing_method == HES_M_SW_POS_LOW;
    wire m_mid = homing_method == HES_M_SW_MID;
    wire m30 = homing_method == HES_M_SW_NEG;
    // edges seen while halted are dropped; the axis is standing
    wire go = enabled && !halted && !start_pulse;

    // phase walk; low-speed switch legs share one pair of states
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            phase <= HES_IDLE;
            leg_neg <= 1'b0;
            leg_fast <= 1'b0;
        end else if (!enabled) begin
            phase <= HES_IDLE; // [RULE14]
            leg_fast <= 1'b0;
        end else if (start_pulse) begin
            if ((m28 || m_mid || m30) && sw_level) begin
                phase <= HES_WAIT_FALL; // [RULE3] [RULE6] [RULE9]
                leg_neg <= !m28;
                leg_fast <= 1'b0;
            end else if (m28 || m_mid || m30) begin
                phase <= HES_HI_NEG; // [RULE1] [RULE4] [RULE7]
                leg_neg <= 1'b1;
                leg_fast <= 1'b1;
            end else if (homing_method == HES_M_IDX_NEG) begin
                phase <= HES_WAIT_INDEX; // [RULE10] [RULE13]
                leg_neg <= 1'b1;
                leg_fast <= 1'b0;
            end else if (homing_method == HES_M_IDX_POS) begin
                phase <= HES_WAIT_INDEX; // [RULE11] [RULE13]
                leg_neg <= 1'b0;
                leg_fast <= 1'b0;
            end else if (homing_method == HES_M_HERE) begin
                phase <= HES_DONE; // [RULE12]
                leg_fast <= 1'b0;
            end else begin
                phase <= HES_IDLE; // [RULE13]
            end
        end else if (go) begin
            case (phase)
                HES_HI_NEG: begin
                    if (neg_limit_i) begin
                        phase <= HES_HI_POS; // [RULE2] [RULE5] [RULE8]
                        leg_neg <= 1'b0;
                    end else if (sw_rise) begin
                        phase <= HES_WAIT_FALL; // [RULE1] [RULE4] [RULE7]
                        leg_neg <= !m28;
                        leg_fast <= 1'b0;
                    end
                end
                HES_HI_POS: begin
                    if (sw_rise) begin
                        phase <= HES_WAIT_FALL; // [RULE2] [RULE5] [RULE8]
                        leg_neg <= !m28;
                        leg_fast <= 1'b0;
                    end
                end
                HES_WAIT_FALL: begin
                    if (sw_fall && m30) begin
                        phase <= HES_DONE; // [RULE8] [RULE9]
                    end else if (sw_fall) begin
                        phase <= HES_WAIT_RISE; // [RULE3] [RULE4] [RULE6]
                        leg_neg <= !leg_neg;
                    end
                end
                HES_WAIT_RISE: begin
                    if (sw_rise) begin
                        phase <= HES_DONE; // [RULE2] [RULE4] [RULE5]
                    end
                end
                HES_WAIT_INDEX: begin
                    if (idx_rise) begin
                        phase <= HES_DONE; // [RULE10] [RULE11]
                    end
                end
                default: begin
                    phase <= phase;
                end
            endcase
        end
    end

    // homed flag: a fresh start clears it, reaching the end sets it;
    // the phase seen beside a start is the old run's, so it must not
    // keep the flag up, else a second homing never reports progress
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            homed <= 1'b0;
        end else if (start_pulse) begin
            homed <= 1'b0; // [RULE18]
        end else if (phase == HES_DONE) begin
            homed <= 1'b1; // [RULE18]
        end
    end

    // ------------------------------------------------------------
    // motion command and state word
    // ------------------------------------------------------------
    wire moving = (phase != HES_IDLE) && (phase != HES_DONE);

    // halt drops run; the option picks a quick or ramped stop
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            motion_o <= '0;
            home_set_o <= 1'b0;
        end else begin
            motion_o.run <= moving && enabled && !halted; // [RULE15]
            motion_o.neg <= leg_neg;
            motion_o.fast <= leg_fast;
            motion_o.quick <= halted
                && (halt_option == HES_HALT_QUICK); // [RULE15]
            home_set_o <= (phase == HES_DONE) && !homed; // [RULE12]
        end
    end

    // state word bits follow halt, speed and homing state
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            drive_state_word <= HES_STATE_RST;
        end else begin
            drive_state_word <= HES_STATE_RST;
            drive_state_word[HES_ST_TARGET] <= halted
                ? speed_zero_i : target_reached_i; // [RULE16]
            drive_state_word[HES_ST_SPEED0] <=
                profile_velocity_operation_i && speed_zero_i; // [RULE17]
            drive_state_word[HES_ST_HOMED] <= homed; // [RULE18]
        end
    end

    assign drive_state_word_o = drive_state_word;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    sequence s_finish;
        (phase == HES_DONE) ##1 homed;
    endsequence

    sequence s_slow_pos;
        (phase == HES_WAIT_FALL) && !leg_neg && !leg_fast;
    endsequence

    AST_M28_ACTIVE_START: assert property ( // [RULE3]
        @(posedge clk_i) disable iff (!resetn_i)
        start_pulse && enabled && m28 && sw_level |=> s_slow_pos)
        else $error("method 28 active start not slow positive");

    AST_HI_NEG_START: assert property ( // [RULE1]
        @(posedge clk_i) disable iff (!resetn_i)
        start_pulse && enabled && m28 && !sw_level
        |=> (phase == HES_HI_NEG) && leg_neg && leg_fast
        ##1 motion_o.fast || !motion_o.run)
        else $error("fast negative search not started");

    AST_M28_RISE: assert property ( // [RULE1]
        @(posedge clk_i) disable iff (!resetn_i)
        go && m28 && (phase == HES_HI_NEG) && !neg_limit_i && sw_rise
        |=> s_slow_pos)
        else $error("rise in method 28 not slow positive");

    AST_LIMIT_REVERSE: assert property ( // [RULE2]
        @(posedge clk_i) disable iff (!resetn_i)
        go && (phase == HES_HI_NEG) && neg_limit_i
        |=> (phase == HES_HI_POS) && !leg_neg && leg_fast)
        else $error("negative limit did not reverse fast");

    AST_MID_FALL: assert property ( // [RULE4]
        @(posedge clk_i) disable iff (!resetn_i)
        go && m_mid && (phase == HES_WAIT_FALL) && leg_neg && sw_fall
        |=> (phase == HES_WAIT_RISE) && !leg_neg)
        else $error("mid method fall did not reverse positive");

    AST_M30_STOP: assert property ( // [RULE9]
        @(posedge clk_i) disable iff (!resetn_i)
        go && m30 && (phase == HES_WAIT_FALL) && sw_fall |=> s_finish)
        else $error("method 30 did not finish on fall");

    AST_INDEX_STOP: assert property ( // [RULE10]
        @(posedge clk_i) disable iff (!resetn_i)
        go && (phase == HES_WAIT_INDEX) && idx_rise
        |=> s_finish ##1 !motion_o.run)
        else $error("index pulse did not stop homing");

    AST_HERE_HOME: assert property ( // [RULE12]
        @(posedge clk_i) disable iff (!resetn_i)
        start_pulse && enabled && (homing_method == HES_M_HERE)
        |=> (phase == HES_DONE) ##1 home_set_o && !motion_o.run)
        else $error("method 35 did not take home in place");

    AST_DISABLE_IDLE: assert property ( // [RULE14]
        @(posedge clk_i) disable iff (!resetn_i)
        !enabled |=> (phase == HES_IDLE) ##1 !motion_o.run)
        else $error("cleared enable did not stop homing");

    AST_HALT_STOP: assert property ( // [RULE15]
        @(posedge clk_i) disable iff (!resetn_i)
        halted |=> !motion_o.run)
        else $error("halt did not drop run");

    AST_TARGET_HALT: assert property ( // [RULE16]
        @(posedge clk_i) disable iff (!resetn_i)
        halted && (speed_zero_i != $past(speed_zero_i))
        |=> drive_state_word_o[HES_ST_TARGET] == $past(speed_zero_i))
        else $error("target bit wrong under halt");

    AST_SPEED_ZERO: assert property ( // [RULE17]
        @(posedge clk_i) disable iff (!resetn_i)
        profile_velocity_operation_i
        |=> drive_state_word_o[HES_ST_SPEED0] == $past(speed_zero_i))
        else $error("speed bit does not follow zero speed");

    AST_HOMED_CLEAR: assert property ( // [RULE18]
        @(posedge clk_i) disable iff (!resetn_i)
        start_pulse
        |=> !homed ##1 !drive_state_word_o[HES_ST_HOMED])
        else $error("homed flag not cleared on new start");

endmodule // hes_sequencer
